/* include/gpio_pkg.sv */
// constants shared by the port reset and mode logic
package gpio_pkg;
  localparam int NUM_PORTS = 7;
  localparam int PORT_WIDTH = 8;
  localparam int STROBE_WIDTH = 3;
  // port indices
  localparam logic [2:0] PORT_FIRST = 3'h0;
  localparam logic [2:0] PORT_SECOND = 3'h1;
  localparam logic [2:0] PORT_THIRD = 3'h2;
  localparam logic [2:0] PORT_FOURTH = 3'h3;
  localparam logic [2:0] PORT_FIFTH = 3'h4;
  localparam logic [2:0] PORT_SIXTH = 3'h5;
  localparam logic [2:0] PORT_SEVENTH = 3'h6;
  // valid bits of a full and of the five-bit port
  localparam logic [7:0] FULL_MASK = 8'hff;
  localparam logic [7:0] NARROW_MASK = 8'h1f;
  // reset values of direction and data bits
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // sixth port bits 7, 5 and 4 carry the test access pins
  localparam logic [7:0] JTAG_PULL_MASK = 8'hb0;
  // seventh port: bits 0..2 strobes, bits 3..4 oscillator
  localparam logic [7:0] STROBE_MASK = 8'h07;
  localparam logic [7:0] OSC_MASK = 8'h18;
  localparam logic [2:0] STROBE_RESET = 3'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

/* verilog/gpio_port_bits.sv */
// direction and data bits of one port
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bits #(
  parameter logic [7:0] VALID_MASK = 8'hff
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write side
  input wire logic dirWrite,
  input wire logic dataWrite,
  input wire logic [7:0] wrData,
  // stored bits
  output logic [7:0] dirBits,
  output logic [7:0] dataBits
);
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (dirWrite) begin
      state_nxt.dir = wrData & VALID_MASK;
    end
    if (dataWrite) begin
      state_nxt.data = wrData & VALID_MASK;
    end
  end

  // async clear drops drive and pull-up select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= {gpio_pkg::DIR_RESET, gpio_pkg::DATA_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign dirBits = state_r.dir;
  assign dataBits = state_r.data;
endmodule
`default_nettype wire

/* verilog/gpio_ports.sv */
// seven general-purpose ports with reset and mode overrides
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Six eight-bit ports and one five-bit port, each bit with its own pull-up select.
// - While reset is low every pin except the legacy-mode third port and strobe bits is released to high impedance without a clock.
// - In legacy mode the third port only drives and keeps driving through reset.
// - The sixth port is analog input and acts as digital port only when the converter is off.
// - With the test port on, pull-ups on sixth port bits 7, 5 and 4 stay on even in reset.
// - In legacy mode the sixth port is input only and never drives.
// - In legacy mode the five-bit port carries strobes, resetting to bits 1,1,0 with bits 3-4 oscillator.
// - A low reset input longer than the least pulse resets the block without a clock.
// - A low program entry pin at the first clock after a power-on reset selects programming mode, else it is ignored.
module gpio_ports (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // static configuration
  input wire logic legacyMode,
  input wire logic jtagEnable,
  input wire logic adcEnable,
  input wire logic powerOnReset,
  input wire logic programEntryPinN,
  // port register writes and reads
  input wire logic [2:0] portSel,
  input wire logic dirWrite,
  input wire logic dataWrite,
  input wire logic [7:0] wrData,
  output logic [7:0] readData,
  output logic programMode,
  // strobes for the five-bit port in legacy mode
  input wire logic [2:0] memStrobe,
  // first port
  input wire logic [7:0] firstPortPinsIn,
  output logic [7:0] firstPortPinsOut,
  output logic [7:0] firstPortPinsOe,
  output logic [7:0] firstPortPullEn,
  // second port
  input wire logic [7:0] secondPortPinsIn,
  output logic [7:0] secondPortPinsOut,
  output logic [7:0] secondPortPinsOe,
  output logic [7:0] secondPortPullEn,
  // third port
  input wire logic [7:0] thirdPortPinsIn,
  output logic [7:0] thirdPortPinsOut,
  output logic [7:0] thirdPortPinsOe,
  output logic [7:0] thirdPortPullEn,
  // fourth port
  input wire logic [7:0] fourthPortPinsIn,
  output logic [7:0] fourthPortPinsOut,
  output logic [7:0] fourthPortPinsOe,
  output logic [7:0] fourthPortPullEn,
  // fifth port
  input wire logic [7:0] fifthPortPinsIn,
  output logic [7:0] fifthPortPinsOut,
  output logic [7:0] fifthPortPinsOe,
  output logic [7:0] fifthPortPullEn,
  // sixth port
  input wire logic [7:0] sixthPortPinsIn,
  output logic [7:0] sixthPortPinsOut,
  output logic [7:0] sixthPortPinsOe,
  output logic [7:0] sixthPortPullEn,
  // seventh port
  input wire logic [4:0] seventhPortPinsIn,
  output logic [4:0] seventhPortPinsOut,
  output logic [4:0] seventhPortPinsOe,
  output logic [4:0] seventhPortPullEn
);
  typedef struct packed {
    logic [2:0] strobe;
    logic powerChecked;
    logic progMode;
    logic [7:0] readData;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic [gpio_pkg::NUM_PORTS-1:0][7:0] pinsIn;
  logic [gpio_pkg::NUM_PORTS-1:0][7:0] dirAll;
  logic [gpio_pkg::NUM_PORTS-1:0][7:0] dataAll;
  logic [gpio_pkg::NUM_PORTS-1:0][7:0] oeAll;
  logic [gpio_pkg::NUM_PORTS-1:0][7:0] outAll;
  logic [gpio_pkg::NUM_PORTS-1:0][7:0] pullAll;

  assign pinsIn[gpio_pkg::PORT_FIRST] = firstPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_SECOND] = secondPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_THIRD] = thirdPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_FOURTH] = fourthPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_FIFTH] = fifthPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_SIXTH] = sixthPortPinsIn;
  assign pinsIn[gpio_pkg::PORT_SEVENTH] = {3'h0, seventhPortPinsIn};

  // one bit store per port, five valid bits on the last
  genvar i;
  generate
    for (i = 0; i < gpio_pkg::NUM_PORTS; i++) begin : g_port
      gpio_port_bits #(
        .VALID_MASK(i == gpio_pkg::NUM_PORTS - 1 ?
                    gpio_pkg::NARROW_MASK : gpio_pkg::FULL_MASK)
      ) u_bits (
        .clk(clk),
        .nrst(nrst),
        .dirWrite(dirWrite && portSel == 3'(i)),
        .dataWrite(dataWrite && portSel == 3'(i)),
        .wrData(wrData),
        .dirBits(dirAll[i]),
        .dataBits(dataAll[i])
      );
    end
  endgenerate

  // pin drive, value and pull-up with mode overrides
  always_comb begin
    for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
      oeAll[p] = dirAll[p];
      outAll[p] = dataAll[p];
      // pull-up when input with data bit set
      pullAll[p] = ~dirAll[p] & dataAll[p];
    end
    // overrides read static mode inputs and the registered strobes
    if (legacyMode) begin
      oeAll[gpio_pkg::PORT_THIRD] = gpio_pkg::FULL_MASK;
      pullAll[gpio_pkg::PORT_THIRD] = gpio_pkg::ZERO_BYTE;
      oeAll[gpio_pkg::PORT_SIXTH] = gpio_pkg::ZERO_BYTE;
      // strobes driven, oscillator bits left to the oscillator
      oeAll[gpio_pkg::PORT_SEVENTH] = gpio_pkg::STROBE_MASK;
      outAll[gpio_pkg::PORT_SEVENTH] = {5'h00, state_r.strobe};
      pullAll[gpio_pkg::PORT_SEVENTH] = gpio_pkg::ZERO_BYTE;
    end
    if (adcEnable) begin
      oeAll[gpio_pkg::PORT_SIXTH] = gpio_pkg::ZERO_BYTE;
      pullAll[gpio_pkg::PORT_SIXTH] = gpio_pkg::ZERO_BYTE;
    end
    if (jtagEnable) begin
      oeAll[gpio_pkg::PORT_SIXTH] = oeAll[gpio_pkg::PORT_SIXTH] &
                                    ~gpio_pkg::JTAG_PULL_MASK;
      // combinational, so it holds while reset is low
      pullAll[gpio_pkg::PORT_SIXTH] = pullAll[gpio_pkg::PORT_SIXTH] |
                                      gpio_pkg::JTAG_PULL_MASK;
    end
  end

  // next state: strobes, program entry check, read data
  always_comb begin
    state_nxt = state_r;
    state_nxt.strobe = memStrobe;
    if (!state_r.powerChecked) begin
      state_nxt.powerChecked = 1'b1;
      state_nxt.progMode = powerOnReset & ~programEntryPinN;
    end
    if (portSel == gpio_pkg::PORT_SEVENTH) begin
      state_nxt.readData = pinsIn[portSel] & gpio_pkg::NARROW_MASK;
    end else if (portSel < gpio_pkg::PORT_SEVENTH) begin
      state_nxt.readData = pinsIn[portSel];
    end else begin
      state_nxt.readData = gpio_pkg::ZERO_BYTE;
    end
  end

  // reset acts at once, with or without clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= {gpio_pkg::STROBE_RESET, 1'b0, 1'b0,
                  gpio_pkg::ZERO_BYTE};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign readData = state_r.readData;
  assign programMode = state_r.progMode;

  assign firstPortPinsOut = outAll[gpio_pkg::PORT_FIRST];
  assign firstPortPinsOe = oeAll[gpio_pkg::PORT_FIRST];
  assign firstPortPullEn = pullAll[gpio_pkg::PORT_FIRST];
  assign secondPortPinsOut = outAll[gpio_pkg::PORT_SECOND];
  assign secondPortPinsOe = oeAll[gpio_pkg::PORT_SECOND];
  assign secondPortPullEn = pullAll[gpio_pkg::PORT_SECOND];
  assign thirdPortPinsOut = outAll[gpio_pkg::PORT_THIRD];
  assign thirdPortPinsOe = oeAll[gpio_pkg::PORT_THIRD];
  assign thirdPortPullEn = pullAll[gpio_pkg::PORT_THIRD];
  assign fourthPortPinsOut = outAll[gpio_pkg::PORT_FOURTH];
  assign fourthPortPinsOe = oeAll[gpio_pkg::PORT_FOURTH];
  assign fourthPortPullEn = pullAll[gpio_pkg::PORT_FOURTH];
  assign fifthPortPinsOut = outAll[gpio_pkg::PORT_FIFTH];
  assign fifthPortPinsOe = oeAll[gpio_pkg::PORT_FIFTH];
  assign fifthPortPullEn = pullAll[gpio_pkg::PORT_FIFTH];
  assign sixthPortPinsOut = outAll[gpio_pkg::PORT_SIXTH];
  assign sixthPortPinsOe = oeAll[gpio_pkg::PORT_SIXTH];
  assign sixthPortPullEn = pullAll[gpio_pkg::PORT_SIXTH];
  assign seventhPortPinsOut = outAll[gpio_pkg::PORT_SEVENTH][4:0];
  assign seventhPortPinsOe = oeAll[gpio_pkg::PORT_SEVENTH][4:0];
  assign seventhPortPullEn = pullAll[gpio_pkg::PORT_SEVENTH][4:0];
endmodule
`default_nettype wire

/* verification/port_checker.sv */
// assertions on pin release, mode overrides, writes and program entry
`timescale 1ns/1ps
`default_nettype none
module port_checker (
  // watched ports
  input wire logic clk, nrst, legacyMode, jtagEnable, adcEnable,
  input wire logic powerOnReset, programEntryPinN, dataWrite, programMode,
  input wire logic [2:0] portSel,
  input wire logic [7:0] wrData, readData, sixthPortPinsIn,
  input wire logic [7:0] firstPortPinsOut, firstPortPinsOe,
  input wire logic [7:0] thirdPortPinsOe, sixthPortPinsOe, sixthPortPullEn,
  input wire logic [4:0] seventhPortPinsOut
);
  default clocking @(posedge clk); endclocking
  property p_rst; !nrst |-> firstPortPinsOe == 8'h00 && !programMode; endproperty
  a_rst: assert property (p_rst) else $error("pins driven in reset");
  property p_leg3; legacyMode |-> thirdPortPinsOe == 8'hff; endproperty
  a_leg3: assert property (p_leg3) else $error("third port released");
  property p_leg6; legacyMode |-> sixthPortPinsOe == 8'h00; endproperty
  a_leg6: assert property (p_leg6) else $error("sixth port drives");
  property p_leg7; !nrst && legacyMode |-> seventhPortPinsOut[2:0] == 3'h3;
  endproperty
  a_leg7: assert property (p_leg7) else $error("strobe reset wrong");
  property p_jtag; jtagEnable |-> (sixthPortPullEn & 8'hb0) == 8'hb0;
  endproperty
  a_jtag: assert property (p_jtag) else $error("test pull-up off");
  property p_adc; adcEnable |-> sixthPortPinsOe == 8'h00; endproperty
  a_adc: assert property (p_adc) else $error("analog pins driven");
  property p_prog; disable iff (!nrst) $rose(nrst) |=>
    programMode == $past(powerOnReset && !programEntryPinN); endproperty
  a_prog: assert property (p_prog) else $error("program mode wrong");
  property p_wr; disable iff (!nrst) dataWrite && portSel == 3'h0 |=>
    firstPortPinsOut == $past(wrData); endproperty
  a_wr: assert property (p_wr) else $error("data write lost");
  property p_rd; disable iff (!nrst) portSel == 3'h5 |=>
    readData == $past(sixthPortPinsIn); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
endmodule
bind gpio_ports port_checker chk_u (.*);
`default_nettype wire

/* verification/board_pins.sv */
// board circuitry seen by the port pins
`timescale 1ns/1ps
`default_nettype none
module board_pins #(
  parameter int W = 53
) (
  input wire logic [W-1:0] oe, out, pull, ext, extOn,
  output logic [W-1:0] lvl
);
  // block drive, else board drive, else pull-up, else drifting
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (extOn[i]) lvl[i] = ext[i];
      else if (pull[i]) lvl[i] = 1'b1;
      else lvl[i] = ~out[i];
    end
  end
endmodule
`default_nettype wire

/* verification/gpio_ports_bench.sv */
// testbench for the port reset and mode block
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_bench;
  logic clk = 1'b0, nrst = 1'b0, legacyMode = 1'b0, jtagEnable = 1'b0;
  logic adcEnable = 1'b0, powerOnReset = 1'b1, programEntryPinN = 1'b1;
  logic dirWrite = 1'b0, dataWrite = 1'b0, programMode;
  logic [2:0] portSel = 3'h0, memStrobe = 3'h0;
  logic [7:0] wrData = 8'h00, readData;
  logic [52:0] oeB, outB, pullB, inB, ext = '0, extOn = '0;
  int fail_count = 0, cmp_count = 0;
  gpio_ports dut_u (.*,
    .firstPortPinsIn(inB[7:0]), .firstPortPinsOut(outB[7:0]),
    .firstPortPinsOe(oeB[7:0]), .firstPortPullEn(pullB[7:0]),
    .secondPortPinsIn(inB[15:8]), .secondPortPinsOut(outB[15:8]),
    .secondPortPinsOe(oeB[15:8]), .secondPortPullEn(pullB[15:8]),
    .thirdPortPinsIn(inB[23:16]), .thirdPortPinsOut(outB[23:16]),
    .thirdPortPinsOe(oeB[23:16]), .thirdPortPullEn(pullB[23:16]),
    .fourthPortPinsIn(inB[31:24]), .fourthPortPinsOut(outB[31:24]),
    .fourthPortPinsOe(oeB[31:24]), .fourthPortPullEn(pullB[31:24]),
    .fifthPortPinsIn(inB[39:32]), .fifthPortPinsOut(outB[39:32]),
    .fifthPortPinsOe(oeB[39:32]), .fifthPortPullEn(pullB[39:32]),
    .sixthPortPinsIn(inB[47:40]), .sixthPortPinsOut(outB[47:40]),
    .sixthPortPinsOe(oeB[47:40]), .sixthPortPullEn(pullB[47:40]),
    .seventhPortPinsIn(inB[52:48]), .seventhPortPinsOut(outB[52:48]),
    .seventhPortPinsOe(oeB[52:48]), .seventhPortPullEn(pullB[52:48]));
  board_pins #(.W(53)) pins_u (.oe(oeB), .out(outB), .pull(pullB),
    .ext(ext), .extOn(extOn), .lvl(inB));
  always #10 clk = ~clk;
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [2:0] s, logic d, logic [7:0] v);
    portSel = s;
    dirWrite = d;
    dataWrite = !d;
    wrData = v;
    step();
    dirWrite = 1'b0;
    dataWrite = 1'b0;
    step();
  endtask
  task automatic rst_on(logic por, logic pin);
    nrst = 1'b0;
    powerOnReset = por;
    programEntryPinN = pin;
    #1;
  endtask
  task automatic rst_off;
    step(8);
    nrst = 1'b1;
    step();
  endtask
  task automatic t_write;
    wr(3'h0, 1'b0, 8'h55);
    chk("firstOut", 8'h55, outB[7:0]);
    wr(3'h0, 1'b1, 8'h0f);
    chk("firstOe", 8'h0f, oeB[7:0]);
    chk("firstPull", 8'h50, pullB[7:0]);
    wr(3'h6, 1'b1, 8'hff);
    wr(3'h7, 1'b1, 8'h00);
    chk("seventhOe", 8'h1f, {3'h0, oeB[52:48]});
    rst_on(1'b0, 1'b1);
    chk("firstOe", 8'h00, oeB[7:0]);
    chk("firstPull", 8'h00, pullB[7:0]);
    chk("seventhOe", 8'h00, {3'h0, oeB[52:48]});
    rst_off();
  endtask
  task automatic t_ports;
    for (int k = 1; k < 5; k++) begin
      wr(3'(k), 1'b0, 8'ha5);
      wr(3'(k), 1'b1, 8'h3c);
      chk("portOut", 8'ha5, outB[8*k +: 8]);
      chk("portOe", 8'h3c, oeB[8*k +: 8]);
      chk("portPull", 8'h81, pullB[8*k +: 8]);
    end
    wr(3'h5, 1'b0, 8'hc0);
    wr(3'h5, 1'b1, 8'h0f);
    chk("sixthOut", 8'hc0, outB[47:40]);
    chk("sixthOe", 8'h0f, oeB[47:40]);
    chk("sixthPull", 8'hc0, pullB[47:40]);
    jtagEnable = 1'b1;
    wr(3'h5, 1'b1, 8'hff);
    chk("sixthOe", 8'h4f, oeB[47:40]);
    chk("sixthPull", 8'hb0, pullB[47:40]);
    adcEnable = 1'b1;
    step();
    chk("sixthOe", 8'h00, oeB[47:40]);
    chk("sixthPull", 8'hb0, pullB[47:40]);
    adcEnable = 1'b0;
    jtagEnable = 1'b0;
    wr(3'h6, 1'b0, 8'hff);
    chk("seventhOut", 8'h1f, {3'h0, outB[52:48]});
    chk("seventhPull", 8'h1f, {3'h0, pullB[52:48]});
  endtask
  task automatic t_read_adc;
    extOn = '1;
    ext[47:40] = 8'ha3;
    portSel = 3'h5;
    step();
    chk("readData", 8'ha3, readData);
    portSel = 3'h7;
    step();
    chk("readData", 8'h00, readData);
    extOn = '0;
    wr(3'h5, 1'b1, 8'hff);
    chk("sixthOe", 8'hff, oeB[47:40]);
    adcEnable = 1'b1;
    step();
    chk("sixthOe", 8'h00, oeB[47:40]);
    adcEnable = 1'b0;
  endtask
  task automatic t_modes;
    legacyMode = 1'b1;
    rst_on(1'b0, 1'b1);
    chk("thirdOe", 8'hff, oeB[23:16]);
    chk("strobeOut", 8'h03, {5'h0, outB[50:48]});
    chk("seventhOe", 8'h07, {3'h0, oeB[52:48]});
    rst_off();
    wr(3'h5, 1'b1, 8'hff);
    chk("sixthOe", 8'h00, oeB[47:40]);
    memStrobe = 3'h5;
    step();
    chk("strobeOut", 8'h05, {5'h0, outB[50:48]});
    legacyMode = 1'b0;
    jtagEnable = 1'b1;
    rst_on(1'b0, 1'b1);
    chk("sixthPull", 8'hb0, pullB[47:40]);
    rst_off();
    jtagEnable = 1'b0;
  endtask
  task automatic t_prog;
    rst_on(1'b1, 1'b0);
    rst_off();
    chk("programMode", 8'h01, {7'h0, programMode});
    programEntryPinN = 1'b1;
    step();
    chk("programMode", 8'h01, {7'h0, programMode});
    rst_on(1'b0, 1'b0);
    rst_off();
    chk("programMode", 8'h00, {7'h0, programMode});
  endtask
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  initial begin
    rst_off();
    t_write();
    t_read_adc();
    t_ports();
    t_modes();
    t_prog();
    summarize();
  end
endmodule
`default_nettype wire
